// file: rtl/uirq_chan.v
// One UART instance worth of interrupt state: sticky raw bits, mask bits.
// Assumes write strobes are one-cycle pulses from the bus slave in the top.
`timescale 1ns/1ps
`default_nettype none
`include "uirq_defines.vh"

module uirq_chan (
   // Clock, reset, enable
   input wire aclk,
   input wire aresetn,
   input wire aclken,
   // Source levels, field order
   input wire [`UIRQ_NSRC-1:0] src,
   // Mask register write
   input wire mask_we,
   input wire [`UIRQ_NSRC-1:0] mask_wd,
   input wire [`UIRQ_NSRC-1:0] mask_be,
   // Clear register write
   input wire clr_we,
   input wire [`UIRQ_NSRC-1:0] clr_wd,
   input wire [`UIRQ_NSRC-1:0] clr_be,
   // State
   output wire [`UIRQ_NSRC-1:0] raw,
   output wire [`UIRQ_NSRC-1:0] mask,
   output wire [`UIRQ_NSRC-1:0] masked
);

   reg [`UIRQ_NSRC-1:0] raw_q;
   reg [`UIRQ_NSRC-1:0] mask_q;

   genvar b;
   generate
      for (b = 0; b < `UIRQ_NSRC; b = b + 1) begin : g_bit
         always @(posedge aclk) begin
            if (!aresetn) begin
               raw_q[b] <= 1'b0;
               mask_q[b] <= 1'b0;
            end else if (aclken) begin
               // A source active in the clear cycle keeps its bit set
               if (src[b])
                  raw_q[b] <= 1'b1;
               else if (clr_we && clr_be[b] && clr_wd[b])
                  raw_q[b] <= 1'b0;
               if (mask_we && mask_be[b])
                  mask_q[b] <= mask_wd[b];
            end
         end
      end
   endgenerate

   assign raw = raw_q;
   assign mask = mask_q;
   assign masked = raw_q & mask_q;

endmodule // uirq_chan

`default_nettype wire

// file: rtl/uirq_defines.vh
// Constants for the UART interrupt status readback block.
// Included by bare name from the design files; definitions only.
`ifndef UIRQ_DEFINES_VH
`define UIRQ_DEFINES_VH

// Number of UART instances and interrupt sources per instance
`define UIRQ_NINST 2
`define UIRQ_NSRC 7

// Instance base addresses, upper 20 address bits
`define UIRQ_BASE0 20'hFFFC0
`define UIRQ_BASE1 20'hFFFC1

// Register offsets within an instance
`define UIRQ_OFF_MASK 12'h038
`define UIRQ_OFF_RAW 12'h03C
`define UIRQ_OFF_MASKED 12'h040
`define UIRQ_OFF_CLEAR 12'h044
`define UIRQ_WORD_MASK 12'hFFC

// Field layout: sources occupy bits 10 down to 4
`define UIRQ_FLD_HI 10
`define UIRQ_FLD_LO 4
`define UIRQ_PAD_HI 21'h000000
`define UIRQ_PAD_LO 4'h0

// Source positions inside the 7-bit field
`define UIRQ_SRC_OVERRUN 6
`define UIRQ_SRC_BREAK 5
`define UIRQ_SRC_PARITY 4
`define UIRQ_SRC_FRAMING 3
`define UIRQ_SRC_TIMEOUT 2
`define UIRQ_SRC_TX 1
`define UIRQ_SRC_RX 0

// Reset values
`define UIRQ_RST_FIELD 7'h00
`define UIRQ_RST_WORD 32'h00000000
`define UIRQ_RST_ADDR 32'h00000000
`define UIRQ_RST_STRB 4'h0

// AXI responses
`define UIRQ_RESP_OKAY 2'h0
`define UIRQ_RESP_SLVERR 2'h2

`endif

// file: rtl/uirq_status.v
// UART interrupt status readback for two UART instances, AXI4-Lite slave.
// Assumes source inputs are synchronous to aclk; one write and one read at a time.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "uirq_defines.vh"

// Notes on behaviour
// - Reading the raw status word at 0x03C gives every source unmasked; writing it does nothing.
// - Raw bit 10 shows the overrun error source before masking.
// - Raw bit 9 shows the break error source before masking.
// - Raw bit 8 shows the parity error source before masking.
// - Raw bit 7 shows the framing error source before masking.
// - Raw bit 6 shows the receive timeout source before masking.
// - Raw bit 5 shows the transmit source before masking.
// - Raw bit 4 shows the receive source before masking.
// - Bits 31:11 and 3:0 of both status words read zero and ignore writes.
// - Reading the masked status word at 0x040 gives sources after masking; writes do nothing.
// - Each of the two UARTs has its own copy, at base 0xFFFC0000 and 0xFFFC1000.
// - A mask bit of one enables its source, zero masks it; masked equals raw AND mask.
// - Masked bits 10 down to 4 give the seven sources after masking.
module uirq_status (
   // Clock, reset, enable
   input wire aclk,
   input wire aresetn,
   input wire aclken,
   // Interrupt sources, one bit per UART instance
   input wire [`UIRQ_NINST-1:0] overrun_error_irq,
   input wire [`UIRQ_NINST-1:0] break_error_irq,
   input wire [`UIRQ_NINST-1:0] parity_error_irq,
   input wire [`UIRQ_NINST-1:0] framing_error_irq,
   input wire [`UIRQ_NINST-1:0] receive_timeout_irq,
   input wire [`UIRQ_NINST-1:0] transmit_irq,
   input wire [`UIRQ_NINST-1:0] receive_irq,
   // Combined interrupt
   output reg irq,
   // AXI4-Lite write address
   input wire [31:0] awaddr,
   input wire [2:0] awprot,
   input wire awvalid,
   output reg awready,
   // AXI4-Lite write data
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   // AXI4-Lite write response
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // AXI4-Lite read address
   input wire [31:0] araddr,
   input wire [2:0] arprot,
   input wire arvalid,
   output reg arready,
   // AXI4-Lite read data
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready
);

   // Held write address and data
   reg aw_held;
   reg w_held;
   reg [31:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;

   // Per-instance state, flattened
   wire [`UIRQ_NINST*`UIRQ_NSRC-1:0] raw_all;
   wire [`UIRQ_NINST*`UIRQ_NSRC-1:0] mask_all;
   wire [`UIRQ_NINST*`UIRQ_NSRC-1:0] masked_all;
   wire [`UIRQ_NINST-1:0] mask_we;
   wire [`UIRQ_NINST-1:0] clr_we;

   // Field bits and their byte enables
   wire [`UIRQ_NSRC-1:0] w_field;
   wire [`UIRQ_NSRC-1:0] w_field_be;

   // Write decode
   wire do_write;
   wire [`UIRQ_NINST-1:0] w_hit;
   wire [11:0] w_off;
   wire w_off_known;
   wire w_ok;

   // Read decode
   wire do_read;
   wire [`UIRQ_NINST-1:0] r_hit;
   wire [11:0] r_off;
   reg [`UIRQ_NSRC-1:0] r_raw;
   reg [`UIRQ_NSRC-1:0] r_mask;
   reg [`UIRQ_NSRC-1:0] r_masked;
   reg [31:0] r_word;
   reg [1:0] r_resp;

   // Next values
   reg next_aw_held;
   reg next_w_held;
   reg next_bvalid;
   reg next_rvalid;

   integer k;

   assign do_write = aw_held & w_held & ~bvalid;
   assign do_read = arvalid & arready;

   // Decode by upper address bits; each UART owns a 4 KB page
   assign w_hit[0] = (aw_addr_q[31:12] == `UIRQ_BASE0);
   assign w_hit[1] = (aw_addr_q[31:12] == `UIRQ_BASE1);
   assign r_hit[0] = (araddr[31:12] == `UIRQ_BASE0);
   assign r_hit[1] = (araddr[31:12] == `UIRQ_BASE1);

   assign w_off = aw_addr_q[11:0] & `UIRQ_WORD_MASK;
   assign r_off = araddr[11:0] & `UIRQ_WORD_MASK;

   // Status words are accepted with OKAY but never stored
   assign w_off_known = (w_off == `UIRQ_OFF_MASK) || (w_off == `UIRQ_OFF_RAW) ||
                        (w_off == `UIRQ_OFF_MASKED) || (w_off == `UIRQ_OFF_CLEAR);
   assign w_ok = (|w_hit) & w_off_known;

   // Only bits 10:4 are decoded; reserved data bits are dropped here
   assign w_field = w_data_q[`UIRQ_FLD_HI:`UIRQ_FLD_LO];

   genvar i;
   generate
      for (i = 0; i < `UIRQ_NSRC; i = i + 1) begin : g_be
         assign w_field_be[i] = w_strb_q[(i + `UIRQ_FLD_LO) / 8];
      end
   endgenerate

   generate
      for (i = 0; i < `UIRQ_NINST; i = i + 1) begin : g_inst
         wire [`UIRQ_NSRC-1:0] src;
         assign src[`UIRQ_SRC_OVERRUN] = overrun_error_irq[i];
         assign src[`UIRQ_SRC_BREAK] = break_error_irq[i];
         assign src[`UIRQ_SRC_PARITY] = parity_error_irq[i];
         assign src[`UIRQ_SRC_FRAMING] = framing_error_irq[i];
         assign src[`UIRQ_SRC_TIMEOUT] = receive_timeout_irq[i];
         assign src[`UIRQ_SRC_TX] = transmit_irq[i];
         assign src[`UIRQ_SRC_RX] = receive_irq[i];
         assign mask_we[i] = do_write & w_hit[i] & (w_off == `UIRQ_OFF_MASK);
         assign clr_we[i] = do_write & w_hit[i] & (w_off == `UIRQ_OFF_CLEAR);
         uirq_chan u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .aclken(aclken),
            .src(src),
            .mask_we(mask_we[i]),
            .mask_wd(w_field),
            .mask_be(w_field_be),
            .clr_we(clr_we[i]),
            .clr_wd(w_field),
            .clr_be(w_field_be),
            .raw(raw_all[i*`UIRQ_NSRC +: `UIRQ_NSRC]),
            .mask(mask_all[i*`UIRQ_NSRC +: `UIRQ_NSRC]),
            .masked(masked_all[i*`UIRQ_NSRC +: `UIRQ_NSRC])
         );
      end
   endgenerate

   // Read multiplexer
   always @* begin
      r_raw = `UIRQ_RST_FIELD;
      r_mask = `UIRQ_RST_FIELD;
      r_masked = `UIRQ_RST_FIELD;
      for (k = 0; k < `UIRQ_NINST; k = k + 1) begin
         if (r_hit[k]) begin
            r_raw = raw_all[k*`UIRQ_NSRC +: `UIRQ_NSRC];
            r_mask = mask_all[k*`UIRQ_NSRC +: `UIRQ_NSRC];
            r_masked = masked_all[k*`UIRQ_NSRC +: `UIRQ_NSRC];
         end
      end
      r_word = `UIRQ_RST_WORD;
      r_resp = `UIRQ_RESP_OKAY;
      if (!(|r_hit)) begin
         r_resp = `UIRQ_RESP_SLVERR;
      end else begin
         case (r_off)
            `UIRQ_OFF_RAW: begin
               r_word = {`UIRQ_PAD_HI, r_raw, `UIRQ_PAD_LO};
            end
            `UIRQ_OFF_MASKED: begin
               r_word = {`UIRQ_PAD_HI, r_masked, `UIRQ_PAD_LO};
            end
            `UIRQ_OFF_MASK: begin
               r_word = {`UIRQ_PAD_HI, r_mask, `UIRQ_PAD_LO};
            end
            `UIRQ_OFF_CLEAR: begin
               // Write-only clear word reads as zero
               r_word = `UIRQ_RST_WORD;
            end
            default: begin
               r_resp = `UIRQ_RESP_SLVERR;
            end
         endcase
      end
   end

   // Channel bookkeeping
   always @* begin
      if (do_write)
         next_aw_held = 1'b0;
      else
         next_aw_held = aw_held | (awvalid & awready);
      if (do_write)
         next_w_held = 1'b0;
      else
         next_w_held = w_held | (wvalid & wready);
      next_bvalid = (bvalid & ~bready) | do_write;
      next_rvalid = (rvalid & ~rready) | do_read;
   end

   // Write channels: address and data are taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= `UIRQ_RST_ADDR;
         w_data_q <= `UIRQ_RST_WORD;
         w_strb_q <= `UIRQ_RST_STRB;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `UIRQ_RESP_OKAY;
      end else if (aclken) begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         if (awvalid && awready)
            aw_addr_q <= awaddr;
         if (wvalid && wready) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         // Ready stays low until the response is taken, so one write at a time
         awready <= ~next_aw_held & ~next_bvalid;
         wready <= ~next_w_held & ~next_bvalid;
         bvalid <= next_bvalid;
         if (do_write)
            bresp <= w_ok ? `UIRQ_RESP_OKAY : `UIRQ_RESP_SLVERR;
      end
   end

   // Read channels
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= `UIRQ_RST_WORD;
         rresp <= `UIRQ_RESP_OKAY;
      end else if (aclken) begin
         arready <= ~next_rvalid;
         rvalid <= next_rvalid;
         if (do_read) begin
            rdata <= r_word;
            rresp <= r_resp;
         end
      end
   end

   // Combined level interrupt; one cycle behind the masked bits
   always @(posedge aclk) begin
      if (!aresetn)
         irq <= 1'b0;
      else if (aclken)
         irq <= |masked_all;
   end

endmodule // uirq_status

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the UART interrupt status readback block.
// Acts as AXI4-Lite master and source driver; the checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
`include "uirq_defines.vh"
module tb;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [1:0] s [0:6];
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, got;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [1:0] rsp;
   wire logic irq, awready, wready, bvalid, arready, rvalid;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int mismatches = 0, n_checks = 0, cyc = 0;
   uirq_status uirq_status_i (.aclk(aclk), .aresetn(aresetn), .aclken(1'h1),
      .overrun_error_irq(s[6]), .break_error_irq(s[5]), .parity_error_irq(s[4]),
      .framing_error_irq(s[3]), .receive_timeout_irq(s[2]), .transmit_irq(s[1]),
      .receive_irq(s[0]), .irq(irq), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   initial forever #10 aclk = ~aclk;
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // A hung handshake ends the run here instead of spinning forever
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 8000) begin
         mismatches++;
         test_done;
      end
   end
   task chk(input string n, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [31:0] ad(input int u, input logic [11:0] o);
      return 32'hFFFC0000 + 32'(u) * 32'h1000 + {20'h0, o};
   endfunction
   task automatic wr(input logic [31:0] a, d);
      logic da = 1'h0;
      logic dw = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(da && dw)) begin
         @(posedge aclk);
         if (awready && !da) begin
            awvalid <= 1'h0;
            da = 1'h1;
         end
         if (wready && !dw) begin
            wvalid <= 1'h0;
            dw = 1'h1;
         end
      end
      do @(posedge aclk); while (!bvalid);
      rsp = bresp;
      bready <= 1'h0;
   endtask
   task automatic rdr(input logic [31:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge aclk); while (!rvalid);
      got = rdata;
      rsp = rresp;
      rready <= 1'h0;
   endtask
   task rc(input logic [31:0] a, e);
      rdr(a);
      chk("rdata", e, got);
   endtask
   task pulse(input int u, input logic [6:0] m);
      @(posedge aclk);
      for (int i = 0; i < 7; i++)
         s[i][u] <= m[i];
      @(posedge aclk);
      for (int i = 0; i < 7; i++)
         s[i][u] <= 1'h0;
   endtask
   task t_reset;
      for (int u = 0; u < 2; u++) begin
         rc(ad(u, 12'h03C), 32'h0);
         rc(ad(u, 12'h040), 32'h0);
      end
      chk("irq", 32'h0, {31'h0, irq});
      $display("reset test done");
   endtask
   task t_raw;
      for (int u = 0; u < 2; u++)
         for (int i = 0; i < 7; i++) begin
            pulse(u, 7'h01 << i);
            rc(ad(u, 12'h03C), 32'h10 << i);
            rc(ad(1 - u, 12'h03C), 32'h0);
            rc(ad(u, 12'h040), 32'h0);
            wr(ad(u, `UIRQ_OFF_CLEAR), 32'h7F0);
         end
      $display("raw test done");
   endtask
   task t_mask;
      wr(ad(1, `UIRQ_OFF_MASK), 32'h550);
      pulse(1, 7'h7F);
      rc(ad(1, 12'h03C), 32'h7F0);
      rc(ad(1, 12'h040), 32'h550);
      rc(ad(0, 12'h040), 32'h0);
      chk("irq", 32'h1, {31'h0, irq});
      wr(ad(1, 12'h03C), 32'hFFFFFFFF);
      chk("bresp", 32'h0, {30'h0, rsp});
      wr(ad(1, 12'h040), 32'h0);
      chk("bresp", 32'h0, {30'h0, rsp});
      rc(ad(1, 12'h040), 32'h550);
      wr(ad(1, `UIRQ_OFF_MASK), 32'h0);
      rc(ad(1, 12'h040), 32'h0);
      rc(ad(1, 12'h03C), 32'h7F0);
      chk("irq", 32'h0, {31'h0, irq});
      rdr(32'hFFFC2040);
      chk("rresp", {30'h0, `UIRQ_RESP_SLVERR}, {30'h0, rsp});
      chk("rdata", 32'h0, got);
      $display("mask test done");
   endtask
   task t_rerst;
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rc(ad(1, 12'h03C), 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      $display("second reset test done");
   endtask
   initial begin
      for (int i = 0; i < 7; i++)
         s[i] = 2'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset;
      t_raw;
      t_mask;
      t_rerst;
      test_done;
   end
endmodule // tb
`default_nettype wire

// file: tb/uirq_status_monitor.sv
// Checker for the UART interrupt status readback, bound to its top module.
// Assumes aclken stays high while a bus transfer is under way.
`timescale 1ns/1ps
`default_nettype none
`include "uirq_defines.vh"
module uirq_mon (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic aclken,
   // Interrupt
   input wire logic irq,
   // Read channels
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // Write channels
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid
);
   logic [31:0] ra;
   wire logic [11:0] ro = ra[11:0] & `UIRQ_WORD_MASK;
   wire logic pg = ra[31:12] == `UIRQ_BASE0 || ra[31:12] == `UIRQ_BASE1;
   wire logic ok = pg && (ro == `UIRQ_OFF_MASK || ro == `UIRQ_OFF_RAW
      || ro == `UIRQ_OFF_MASKED || ro == `UIRQ_OFF_CLEAR);
   // Address of the read in flight, kept so its answer can be judged
   always_ff @(posedge aclk)
      if (!aresetn)
         ra <= 32'h0;
      else if (aclken && arvalid && arready)
         ra <= araddr;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rst; $rose(aresetn) |-> !rvalid && !bvalid && !irq; endproperty
   a_rst: assert property (p_rst) else $error("busy after reset");
   property p_rsv; rvalid |-> rdata[31:11] == 21'h0 && rdata[3:0] == 4'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_ans; aclken && arvalid && arready |=> rvalid; endproperty
   a_ans: assert property (p_ans) else $error("no read answer");
   property p_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data dropped");
   property p_map; rvalid |-> rresp == (ok ? 2'h0 : 2'h2) && (ok || rdata == 32'h0); endproperty
   a_map: assert property (p_map) else $error("wrong read response");
   property p_irq; $rose(rvalid) && ok && ro == 12'h040 && rdata != 32'h0 |-> irq; endproperty
   a_irq: assert property (p_irq) else $error("irq low with masked bits");
   property p_wr; aclken && awvalid && awready && wvalid && wready |=> ##1 bvalid; endproperty
   a_wr: assert property (p_wr) else $error("no write answer");
   property p_blk; rvalid |-> !arready; endproperty
   a_blk: assert property (p_blk) else $error("read taken while busy");
endmodule // uirq_mon
bind uirq_status uirq_mon uirq_mon_i (.aclk(aclk), .aresetn(aresetn), .aclken(aclken),
   .irq(irq), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rresp(rresp), .rvalid(rvalid), .rready(rready), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid));
`default_nettype wire
